/* File: core/sadc_pkg.sv */
// Shared constants and types for the converter control and its host.
package sadc_pkg;

    // External clock rate of the block.
    localparam int unsigned SADC_CLK_HZ = 20_000_000;

    // Width of the conversion result.
    localparam int unsigned SADC_BITS = 8;

    // Ratio of the external clock to the internal sequencing clock.
    localparam int unsigned SADC_DIV = 8;

    // Comparisons per conversion and external clock cycles they take.
    localparam int unsigned SADC_STEPS = 8;
    localparam int unsigned SADC_CONV_CYC = SADC_STEPS * SADC_DIV;

    // Length of the completion set pulse in external clock periods.
    localparam int unsigned SADC_SET_CYC = 8;

    // Reset, mask load and full-scale values of the result path.
    localparam logic [7:0] SADC_RESULT_RST = 8'h00;
    localparam logic [7:0] SADC_MASK_MSB = 8'h80;
    localparam logic [7:0] SADC_MASK_NONE = 8'h00;
    localparam logic [7:0] SADC_FULL_SCALE = 8'hff;

    // Set pulse counter load value and width.
    localparam logic [3:0] SADC_SET_LOAD = 4'h7;
    localparam logic [3:0] SADC_SET_ZERO = 4'h0;
    localparam logic [3:0] SADC_SET_ONE = 4'h1;

    // Host strobe widths in clock cycles.
    localparam logic [3:0] SADC_WR_LOW_CYC = 4'h2;
    localparam logic [3:0] SADC_RD_LOW_CYC = 4'h2;

    // Device sequencing states.
    typedef enum logic [2:0] {
        SADC_ST_IDLE = 3'b001,
        SADC_ST_HOLD = 3'b010,
        SADC_ST_RUN = 3'b100
    } sadc_state_t;

    // Host control states.
    typedef enum logic [2:0] {
        SADC_H_IDLE = 3'b001,
        SADC_H_START = 3'b010,
        SADC_H_READ = 3'b100
    } sadc_hstate_t;

endpackage

/* File: core/sadc_bus_if.sv */
// Pin bundle joining the converter control and its host.
`timescale 1ns/1ps
`default_nettype none

interface sadc_bus_if;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic conversion_done_n;
    logic [7:0] data_out;
    logic data_oe_n;

    modport device (
        input cs_n,
        input wr_n,
        input rd_n,
        output conversion_done_n,
        output data_out,
        output data_oe_n
    );

    modport host (
        output cs_n,
        output wr_n,
        output rd_n,
        input conversion_done_n,
        input data_out,
        input data_oe_n
    );
endinterface

`default_nettype wire

/* File: core/sadc_tick_div.sv */
// Free-running divider that gives a one-cycle enable every N clocks.
`timescale 1ns/1ps
`default_nettype none

module sadc_tick_div #(
    parameter int unsigned N = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Enable pulse
    output logic tick
);
    localparam int unsigned W = (N > 1) ? $clog2(N) : 1;
    localparam logic [W-1:0] LAST = W'(N - 1);
    localparam logic [W-1:0] ZERO = '0;
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_r;
    wire at_last = (cnt_r == LAST);
    wire [W-1:0] cnt_nxt = at_last ? ZERO : cnt_r + ONE;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_r <= ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = at_last;
endmodule

`default_nettype wire

/* File: core/sadc_device.sv */
// Successive-approximation conversion control: start logic, bit search, latch and done flag.
//
// How it works
// - MSB first, 8 steps in 64 clocks, then latch.
// - Result is straight binary, all ones full scale.
// - Done falls once the result is latched.
// - A new start aborts and restarts conversion.
// - Free run: select low, done fed to start.
// - Host gives one start pulse after power-up.
// - Start clears search register and sequencer.
// - Held in reset while select and start low.
// - Conversion begins 1 to 8 clocks after release.
// - Start clears done flag; release loads sequencer head.
// - Sequencing runs at one eighth of clock.
// - Under continuous read, done still low 8 clocks.
// - Free run: done low edge retriggers, short pulse.
// - Select and read low clear done, drive data.
// - Select, start and read are active low.
// - Standalone host may ground select, pulse strobes.
`timescale 1ns/1ps
`default_nettype none

module sadc_device
    import sadc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins toward the host
    sadc_bus_if.device bus,
    // Comparator side
    output logic [7:0] trial_code,
    input wire logic comp_above,
    // Status
    output logic conv_busy
);

    // Internal sequencing enable, one cycle in eight.
    logic seq_tick;

    sadc_tick_div #(
        .N(SADC_DIV)
    ) u_div (
        .clk(clk),
        .resetn(resetn),
        .tick(seq_tick)
    );

    // Pin decode; every control pin counts as asserted when low.
    wire start_cond = !bus.cs_n && !bus.wr_n;
    wire read_cond = !bus.cs_n && !bus.rd_n;

    // State and datapath registers.
    sadc_state_t state_r;
    sadc_state_t state_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] sar_r;
    logic [7:0] sar_nxt;
    logic [7:0] result_r;
    logic [7:0] result_nxt;
    logic [3:0] set_cnt_r;
    logic [3:0] set_cnt_nxt;
    logic done_flag_r;
    logic done_flag_nxt;

    // Decode of the current state.
    wire in_idle = (state_r == SADC_ST_IDLE);
    wire in_hold = (state_r == SADC_ST_HOLD);
    wire in_run = (state_r == SADC_ST_RUN);

    // The trial word adds the bit under test to the bits already kept.
    wire [7:0] trial_word = sar_r | mask_r;
    wire [7:0] sar_step = comp_above ? trial_word : sar_r;
    wire step_now = in_run && seq_tick;
    wire step_last = mask_r[0];
    wire latch_now = step_now && step_last;
    wire [7:0] mask_shift = {1'b0, mask_r[7:1]};

    // The head of the sequencer is passed on only once the start pins are released.
    wire release_now = in_hold && seq_tick && !start_cond;

    // Completion set pulse lasts eight clocks counted from the latch edge.
    wire set_active = (set_cnt_r != SADC_SET_ZERO);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SADC_ST_IDLE: begin
                state_nxt = SADC_ST_IDLE;
            end
            SADC_ST_HOLD: begin
                if (release_now) begin
                    state_nxt = SADC_ST_RUN;
                end
            end
            SADC_ST_RUN: begin
                if (latch_now) begin
                    state_nxt = SADC_ST_IDLE;
                end
            end
        endcase
        // A start strobe overrides everything, also in the middle of a conversion.
        if (start_cond) begin
            state_nxt = SADC_ST_HOLD;
        end
    end

    always_comb begin
        mask_nxt = mask_r;
        sar_nxt = sar_r;
        if (start_cond) begin
            mask_nxt = SADC_MASK_NONE;
            sar_nxt = SADC_RESULT_RST;
        end else if (release_now) begin
            mask_nxt = SADC_MASK_MSB;
            sar_nxt = SADC_RESULT_RST;
        end else if (step_now) begin
            mask_nxt = mask_shift;
            sar_nxt = sar_step;
        end
    end

    // The latch changes only on completion.
    assign result_nxt = latch_now ? sar_step : result_r;

    always_comb begin
        set_cnt_nxt = set_cnt_r;
        if (start_cond) begin
            set_cnt_nxt = SADC_SET_ZERO;
        end else if (latch_now) begin
            set_cnt_nxt = SADC_SET_LOAD;
        end else if (set_active) begin
            set_cnt_nxt = set_cnt_r - SADC_SET_ONE;
        end
    end

    // Start clears the flag even against the set pulse, which keeps the free
    // running done pulse short; a read clears it only once the set pulse is over.
    always_comb begin
        done_flag_nxt = done_flag_r;
        if (start_cond) begin
            done_flag_nxt = 1'b0;
        end else if (latch_now || set_active) begin
            done_flag_nxt = 1'b1;
        end else if (read_cond) begin
            done_flag_nxt = 1'b0;
        end
    end

    // Each register has its own short clocked process.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= SADC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_r <= SADC_MASK_NONE;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sar_r <= SADC_RESULT_RST;
        end else begin
            sar_r <= sar_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_r <= SADC_RESULT_RST;
        end else begin
            result_r <= result_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            set_cnt_r <= SADC_SET_ZERO;
        end else begin
            set_cnt_r <= set_cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            done_flag_r <= 1'b0;
        end else begin
            done_flag_r <= done_flag_nxt;
        end
    end

    // Pin outputs.
    assign bus.conversion_done_n = !done_flag_r;
    assign bus.data_out = result_r;
    assign bus.data_oe_n = !read_cond;

    // Comparator side: the trial word is only meaningful while running.
    assign trial_code = in_run ? trial_word : SADC_RESULT_RST;
    assign conv_busy = in_hold || in_run || (in_idle && start_cond);

endmodule

`default_nettype wire

/* File: core/sadc_host.sv */
// Host end: drives select, start and read strobes and collects results.
`timescale 1ns/1ps
`default_nettype none

module sadc_host
    import sadc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins toward the converter
    sadc_bus_if.host bus,
    // User requests
    input wire logic start_req,
    input wire logic read_req,
    input wire logic free_run,
    // User results
    output logic [7:0] result,
    output logic result_valid,
    output logic busy
);
    sadc_hstate_t state_r;
    sadc_hstate_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic boot_r;
    logic [7:0] result_r;
    logic valid_r;

    wire in_idle = (state_r == SADC_H_IDLE);
    wire in_start = (state_r == SADC_H_START);
    wire in_read = (state_r == SADC_H_READ);
    wire cnt_end = (cnt_r == SADC_SET_ONE);
    // One start pulse is forced after reset before anything else.
    wire go_start = in_idle && (boot_r || (start_req && !free_run));
    wire go_read = in_idle && !boot_r && read_req && !go_start;
    wire read_take = in_read && cnt_end && !bus.data_oe_n;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            SADC_H_IDLE: begin
                if (go_start) begin
                    state_nxt = SADC_H_START;
                    cnt_nxt = SADC_WR_LOW_CYC;
                end else if (go_read) begin
                    state_nxt = SADC_H_READ;
                    cnt_nxt = SADC_RD_LOW_CYC;
                end
            end
            SADC_H_START, SADC_H_READ: begin
                cnt_nxt = cnt_r - SADC_SET_ONE;
                if (cnt_end) begin
                    state_nxt = SADC_H_IDLE;
                    cnt_nxt = SADC_SET_ZERO;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= SADC_H_IDLE;
            cnt_r <= SADC_SET_ZERO;
            boot_r <= 1'b1;
            result_r <= SADC_RESULT_RST;
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            boot_r <= boot_r && !go_start;
            result_r <= read_take ? bus.data_out : result_r;
            valid_r <= read_take;
        end
    end

    // Standalone style: select is held low, strobes are low pulses.
    assign bus.cs_n = 1'b0;
    // In free run the done pin itself is the start strobe.
    assign bus.wr_n = in_start ? 1'b0 : (free_run ? bus.conversion_done_n : 1'b1);
    assign bus.rd_n = !in_read;

    assign result = result_r;
    assign result_valid = valid_r;
    assign busy = !in_idle || boot_r;
endmodule

`default_nettype wire

/* File: test/sadc_monitor.sv */
// Concurrent checks on the pins between the converter control and its host.
`timescale 1ns/1ps
`default_nettype none

module sadc_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic conversion_done_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    logic [7:0] rel_r;
    logic [3:0] low_r;
    wire start_c = !cs_n && !wr_n;
    wire read_c = !cs_n && !rd_n && wr_n;
    // Cycles since the start pins were last held, and cycles done has been low.
    always_ff @(posedge clk) begin
        rel_r <= !resetn ? 8'hff : start_c ? 8'h00 : rel_r + {7'h00, rel_r != 8'hff};
        low_r <= (!resetn || conversion_done_n) ? 4'h0 : low_r + {3'h0, low_r != 4'hf};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_OE: assert property (data_oe_n == (cs_n || rd_n))
        else $error("data enable does not follow select and read");
    AST_CS: assert property (cs_n == 1'b0)
        else $error("select not held low");
    AST_START_CLR: assert property (start_c |=> conversion_done_n)
        else $error("start did not release done");
    AST_HOLD: assert property (start_c ##1 start_c |-> conversion_done_n)
        else $error("done seen while held in start");
    AST_DONE_TIME: assert property ($fell(conversion_done_n) |-> rel_r >= 8'h41 && rel_r <= 8'h48)
        else $error("done fell at wrong distance from start");
    AST_LATCH: assert property ($changed(data_out) |-> $fell(conversion_done_n))
        else $error("result changed outside completion");
    AST_SET_WIDTH: assert property ($rose(conversion_done_n) && !$past(start_c) |-> low_r >= 4'h8)
        else $error("done low pulse too short");
    AST_READ_CLR: assert property (!conversion_done_n && low_r >= 4'ha && read_c |=> conversion_done_n)
        else $error("read did not release done");
    AST_BOOT: assert property ($rose(resetn) |-> ##[1:4] !wr_n)
        else $error("no start after reset");
    cover property ($fell(conversion_done_n));
    cover property (start_c && rel_r > 8'h0a && rel_r < 8'h3c);
    cover property ($rose(conversion_done_n) && read_c);
endmodule

`default_nettype wire

/* File: test/sar_adc_conversion_control_tb.sv */
// Self-checking bench joining the converter control to its host.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control_tb
    import sadc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic start_req = 1'b0;
    logic read_req = 1'b0;
    logic free_run = 1'b0;
    logic [7:0] analog_r = 8'h00;
    logic [7:0] trial_code;
    logic [7:0] result;
    logic conv_busy;
    logic result_valid;
    logic busy;
    int n_mismatch = 0;
    int total_checks = 0;
    // The comparator says whether the input is at or above the trial code.
    wire comp_above = analog_r >= trial_code;

    sadc_bus_if bus ();
    sadc_device u_sadc_device (.clk(clk), .resetn(resetn), .bus(bus), .trial_code(trial_code),
        .comp_above(comp_above), .conv_busy(conv_busy));
    sadc_host u_sadc_host (.clk(clk), .resetn(resetn), .bus(bus), .start_req(start_req),
        .read_req(read_req), .free_run(free_run), .result(result),
        .result_valid(result_valid), .busy(busy));
    sadc_monitor u_sadc_monitor (.clk(clk), .resetn(resetn), .cs_n(bus.cs_n), .wr_n(bus.wr_n),
        .rd_n(bus.rd_n), .conversion_done_n(bus.conversion_done_n), .data_out(bus.data_out),
        .data_oe_n(bus.data_oe_n));

    always #25 clk = ~clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
        chk({7'h00, busy}, 8'h00);
    endtask

    task automatic go;
        start_req = 1'b1;
        tick(1);
        start_req = 1'b0;
        wait_idle();
    endtask

    task automatic wait_done;
        for (int i = 0; i < 100 && bus.conversion_done_n !== 1'b0; i++) tick(1);
        chk({7'h00, bus.conversion_done_n}, 8'h00);
    endtask

    task automatic t_read(input logic [7:0] exp);
        read_req = 1'b1;
        tick(1);
        read_req = 1'b0;
        for (int i = 0; i < 10 && result_valid !== 1'b1; i++) tick(1);
        chk({7'h00, result_valid}, 8'h01);
        chk(result, exp);
        chk({7'h00, bus.conversion_done_n}, 8'h01);
        wait_idle();
    endtask

    task automatic t_convert(input logic [7:0] v);
        analog_r = v;
        go();
        for (int i = 0; i < 20 && trial_code === 8'h00; i++) tick(1);
        chk(trial_code, 8'h80);
        chk({7'h00, conv_busy}, 8'h01);
        tick(7);
        chk(trial_code, 8'h80);
        tick(1);
        chk(trial_code, {v[7], 7'h40});
        wait_done();
        tick(10);
        t_read(v);
    endtask

    task automatic t_abort;
        analog_r = 8'h33;
        go();
        tick(20);
        analog_r = 8'hc6;
        go();
        wait_done();
        // A read inside the set pulse takes the data but leaves done low.
        read_req = 1'b1;
        tick(1);
        read_req = 1'b0;
        for (int i = 0; i < 10 && result_valid !== 1'b1; i++) tick(1);
        chk(result, 8'hc6);
        chk({7'h00, bus.conversion_done_n}, 8'h00);
        wait_idle();
        tick(10);
        t_read(8'hc6);
    endtask

    task automatic t_hold;
        analog_r = 8'h0f;
        tick(40);
        t_read(8'hc6);
    endtask

    task automatic t_free;
        int falls;
        int lows;
        logic prev;
        falls = 0;
        lows = 0;
        prev = 1'b1;
        analog_r = 8'h96;
        go();
        free_run = 1'b1;
        repeat (300) begin
            tick(1);
            falls += int'(prev && !bus.conversion_done_n);
            lows += int'(!bus.conversion_done_n);
            prev = bus.conversion_done_n;
        end
        chk(8'(falls >= 4), 8'h01);
        chk(8'(lows), 8'(falls));
        chk(bus.data_out, 8'h96);
        free_run = 1'b0;
        tick(100);
    endtask

    initial begin
        #(20000 * 50);
        n_mismatch++;
        test_done();
    end

    initial begin
        logic [7:0] vals [4];
        vals = '{8'ha5, SADC_FULL_SCALE, 8'h00, 8'h5a};
        tick(8);
        resetn = 1'b1;
        wait_idle();
        foreach (vals[i]) t_convert(vals[i]);
        t_abort();
        t_hold();
        t_free();
        resetn = 1'b0;
        tick(3);
        resetn = 1'b1;
        wait_idle();
        t_convert(8'h3c);
        test_done();
    end
endmodule

`default_nettype wire
